// File: hw/tsb_core.sv
// Broadcast trigger pulses and step delay timing of the trigger sequencer, with APB registers.
// What this block does
// - Broadcast with clock bit set pulses compare1 clock.
// - Bits 3..0 pulse compare channels 4..1 triggers.
// - Only option 1111 step uses broadcast enables.
// - Enable, delay and counter0 limit registers locked while enabled and running.
// - Step delay limit is 16-bit read/write.
// - Each step lasts limit plus one clock.
// - Counter0 limit is separate 16-bit register.
//
// Local design decisions: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module tsb_core
    import tsb_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        i_step_start,
    input  wire logic [3:0]  i_step_option_command,
    output logic             o_step_done,
    output logic             o_step_busy,
    output logic [15:0]      o_loop_counter0_limit,
    output logic             o_sequencer_module_enable,
    output logic             o_sequencer_run,
    output tsb_bcast_s       o_bcast
);
    logic [15:0] broadcast_trigger_enable;
    logic [15:0] step_delay_limit;
    logic [15:0] loop_counter0_limit;
    logic        sequencer_module_enable;
    logic        sequencer_run;
    logic [15:0] step_count;
    tsb_state_e  state;

    // Exact match only: an aliased register would give software a way around the lock.
    function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
        return a == ofs;
    endfunction

    // Writes complete in the access phase; the slave never stalls.
    wire wr_en  = psel & penable & pwrite;
    wire locked = sequencer_module_enable & sequencer_run;
    wire mapped = hit(paddr, TSB_OFS_BCAST_EN) | hit(paddr, TSB_OFS_STEP_DLY) |
                  hit(paddr, TSB_OFS_C0_LIMIT) | hit(paddr, TSB_OFS_CONTROL) |
                  hit(paddr, TSB_OFS_STATUS);
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    // A refused write while running raises no error, so software sees the lock only by reading back.
    // The counter-0 limit is frozen with the other two, so a running loop never picks up a new count.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            broadcast_trigger_enable <= TSB_RST_BCAST_EN;
            step_delay_limit         <= TSB_RST_STEP_DLY;
            loop_counter0_limit      <= TSB_RST_C0_LIMIT;
        end else if (wr_en && !locked) begin
            if (hit(paddr, TSB_OFS_BCAST_EN))
                broadcast_trigger_enable <= pwdata[15:0];
            if (hit(paddr, TSB_OFS_STEP_DLY))
                step_delay_limit <= pwdata[15:0];
            if (hit(paddr, TSB_OFS_C0_LIMIT))
                loop_counter0_limit <= pwdata[15:0];
        end
    end

    // Control stays writable while running, otherwise software could never stop the sequencer.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            sequencer_module_enable <= 1'b0;
            sequencer_run           <= 1'b0;
        end else if (wr_en && hit(paddr, TSB_OFS_CONTROL)) begin
            sequencer_module_enable <= pwdata[TSB_BIT_MOD_EN];
            sequencer_run           <= pwdata[TSB_BIT_RUN];
        end
    end

    // Read data is driven only during a read, so the bus stays quiet between transfers.
    always_comb begin
        prdata = 32'h00000000;
        if (psel && !pwrite) begin
            case (1'b1)
                hit(paddr, TSB_OFS_BCAST_EN): prdata = {16'h0000, broadcast_trigger_enable};
                hit(paddr, TSB_OFS_STEP_DLY): prdata = {16'h0000, step_delay_limit};
                hit(paddr, TSB_OFS_C0_LIMIT): prdata = {16'h0000, loop_counter0_limit};
                hit(paddr, TSB_OFS_CONTROL):  prdata = {30'h00000000, sequencer_run, sequencer_module_enable};
                hit(paddr, TSB_OFS_STATUS):   prdata = {15'h0000, o_step_busy, step_count};
                default:                      prdata = 32'h00000000;
            endcase
        end
    end

    // Step timer: a step accepted in cycle 0 finishes limit+1 cycles later.
    wire step_take = i_step_start & locked & (state == TSB_IDLE);
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state      <= TSB_IDLE;
            step_count <= 16'h0000;
        end else begin
            case (state)
                TSB_IDLE: if (step_take) begin
                    state      <= TSB_BUSY;
                    step_count <= step_delay_limit;
                end
                TSB_BUSY: if (step_count == 16'h0000) state <= TSB_IDLE;
                          else step_count <= step_count - TSB_BASE_DELAY;
                default: state <= TSB_IDLE;
            endcase
            // Dropping enable or run aborts a step at once; a pulse already sent is not withdrawn.
            if (!locked) state <= TSB_IDLE;
        end
    end
    assign o_step_busy = (state == TSB_BUSY);
    assign o_step_done = o_step_busy & (step_count == 16'h0000);

    // Outputs are registered single-cycle pulses one edge after the take.
    // The channels therefore see the pulse in the first busy cycle of the broadcast step.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_bcast <= '0;
        end else if (step_take && i_step_option_command == TSB_OPT_BCAST) begin
            o_bcast.clk1 <= broadcast_trigger_enable[TSB_BIT_CLK1];
            o_bcast.trig <= broadcast_trigger_enable[TSB_BIT_TRIG_LO +: 4];
        end else begin
            o_bcast <= '0;
        end
    end

    assign o_loop_counter0_limit     = loop_counter0_limit;
    assign o_sequencer_module_enable = sequencer_module_enable;
    assign o_sequencer_run           = sequencer_run;

    sequence s_take_bcast;
        step_take && i_step_option_command == TSB_OPT_BCAST;
    endsequence
    AST_CLK1: assert property (@(posedge i_clk) disable iff (i_rst)
        s_take_bcast |=> o_bcast.clk1 == $past(broadcast_trigger_enable[TSB_BIT_CLK1]))
        else $error("clock pulse mismatch");
    AST_TRIG: assert property (@(posedge i_clk) disable iff (i_rst)
        s_take_bcast |=> o_bcast.trig == $past(broadcast_trigger_enable[3:0]))
        else $error("trigger pulse mismatch");
    AST_OTHER: assert property (@(posedge i_clk) disable iff (i_rst)
        !$past(step_take && i_step_option_command == TSB_OPT_BCAST) |-> o_bcast == '0)
        else $error("pulse without broadcast step");
    AST_LOCK: assert property (@(posedge i_clk) disable iff (i_rst)
        locked && wr_en |=> $stable(broadcast_trigger_enable) && $stable(step_delay_limit))
        else $error("write while locked");
    AST_WRITE: assert property (@(posedge i_clk) disable iff (i_rst)
        wr_en && !locked && hit(paddr, TSB_OFS_STEP_DLY) |=> step_delay_limit == $past(pwdata[15:0]))
        else $error("delay write lost");
    AST_ZERO: assert property (@(posedge i_clk) disable iff (i_rst)
        step_take && step_delay_limit == 16'h0000 ##1 locked |-> o_step_done)
        else $error("zero delay step not one clock");
    sequence s_take_two;
        step_take && step_delay_limit == 16'h0002 ##1 locked [*3];
    endsequence
    AST_TWO: assert property (@(posedge i_clk) disable iff (i_rst)
        s_take_two |-> !$past(o_step_done, 2) && !$past(o_step_done) && o_step_done)
        else $error("step length wrong");
    AST_C0: assert property (@(posedge i_clk) disable iff (i_rst)
        wr_en && !locked && hit(paddr, TSB_OFS_C0_LIMIT) |=> o_loop_counter0_limit == $past(pwdata[15:0]))
        else $error("counter0 limit write lost");
    AST_PULSE: assert property (@(posedge i_clk) disable iff (i_rst)
        o_bcast != '0 |=> o_bcast == '0)
        else $error("broadcast pulse wider than one clock");

    // Step timer and register checks. AST_LOAD and AST_COUNT watch step_count, so a wrong count shows up long
    // before a step ends early or late at the port.
    sequence s_locked_write;
        wr_en && locked;
    endsequence
    sequence s_counting;
        o_step_busy && step_count != 16'h0000 && locked;
    endsequence

    AST_LOAD: assert property (@(posedge i_clk) disable iff (i_rst)
        step_take |=> o_step_busy && step_count == $past(step_delay_limit))
        else $error("step count not loaded at start");

    AST_COUNT: assert property (@(posedge i_clk) disable iff (i_rst)
        s_counting |=> o_step_busy && step_count == $past(step_count) - TSB_BASE_DELAY)
        else $error("step count did not fall by one");

    AST_END: assert property (@(posedge i_clk) disable iff (i_rst)
        o_step_done |=> !o_step_busy)
        else $error("step still busy after done");

    AST_DONE_ONCE: assert property (@(posedge i_clk) disable iff (i_rst)
        o_step_done |=> !o_step_done)
        else $error("step done wider than one clock");

    AST_ABORT: assert property (@(posedge i_clk) disable iff (i_rst)
        !locked |=> !o_step_busy)
        else $error("step runs while not executing");

    AST_C0_LOCK: assert property (@(posedge i_clk) disable iff (i_rst)
        s_locked_write |=> $stable(loop_counter0_limit))
        else $error("counter0 limit written while locked");

    AST_EN_WRITE: assert property (@(posedge i_clk) disable iff (i_rst)
        wr_en && !locked && hit(paddr, TSB_OFS_BCAST_EN) |=> broadcast_trigger_enable == $past(pwdata[15:0]))
        else $error("enable write lost while unlocked");

    AST_READ_DLY: assert property (@(posedge i_clk) disable iff (i_rst)
        psel && !pwrite && hit(paddr, TSB_OFS_STEP_DLY) |-> prdata == {16'h0000, step_delay_limit})
        else $error("step delay read back wrong");

    AST_READ_EN: assert property (@(posedge i_clk) disable iff (i_rst)
        psel && !pwrite && hit(paddr, TSB_OFS_BCAST_EN) |-> prdata == {16'h0000, broadcast_trigger_enable})
        else $error("enable register read back wrong");

    AST_QUIET: assert property (@(posedge i_clk) disable iff (i_rst)
        !o_step_busy |-> o_bcast == '0)
        else $error("broadcast pulse outside a step");

    AST_CTRL: assert property (@(posedge i_clk) disable iff (i_rst)
        wr_en && hit(paddr, TSB_OFS_CONTROL) |=> o_sequencer_run == $past(pwdata[TSB_BIT_RUN]))
        else $error("run control write lost");
endmodule // tsb_core
`default_nettype wire

// File: hw/tsb_pkg.sv
// Package with register map, field layout and types of the trigger sequencer broadcast and delay block.
package tsb_pkg;
    localparam logic [11:0] TSB_OFS_BCAST_EN  = 12'h000;
    localparam logic [11:0] TSB_OFS_STEP_DLY  = 12'h004;
    localparam logic [11:0] TSB_OFS_C0_LIMIT  = 12'h008;
    localparam logic [11:0] TSB_OFS_CONTROL   = 12'h00C;
    localparam logic [11:0] TSB_OFS_STATUS    = 12'h010;
    localparam logic [15:0] TSB_RST_BCAST_EN  = 16'h0000;
    localparam logic [15:0] TSB_RST_STEP_DLY  = 16'h0000;
    localparam logic [15:0] TSB_RST_C0_LIMIT  = 16'h0000;
    localparam int          TSB_BIT_CLK1      = 4;
    localparam int          TSB_BIT_TRIG_LO   = 0;
    localparam int          TSB_BIT_MOD_EN    = 0;
    localparam int          TSB_BIT_RUN       = 1;
    localparam logic [3:0]  TSB_OPT_BCAST     = 4'hF;
    localparam logic [15:0] TSB_BASE_DELAY    = 16'h0001;

    typedef struct packed {
        logic       clk1;
        logic [3:0] trig;
    } tsb_bcast_s;

    typedef enum logic [1:0] {
        TSB_IDLE = 2'b01,
        TSB_BUSY = 2'b10
    } tsb_state_e;
endpackage : tsb_pkg

// File: tb/tsb_oc_model.sv
// Model of the four compare channels, counting broadcast pulses.
`timescale 1ns/1ps
`default_nettype none
module tsb_oc_model
    import tsb_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire tsb_bcast_s i_bcast,
    output logic [7:0]      o_clk_cnt,
    output logic [3:0][7:0] o_trig_cnt
);
    // A pulse held two cycles counts twice, so long pulses show up in the totals.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_clk_cnt  <= 8'h00;
            o_trig_cnt <= '0;
        end else begin
            o_clk_cnt <= o_clk_cnt + {7'h00, i_bcast.clk1};
            for (int c = 0; c < 4; c++) begin
                o_trig_cnt[c] <= o_trig_cnt[c] + {7'h00, i_bcast.trig[c]};
            end
        end
    end
endmodule // tsb_oc_model
`default_nettype wire

// File: tb/testbench.sv
// Self-checking bench for the broadcast and step delay block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin mismatches++; $display("Error at %0t: %h not %h", $time, a, e); end end
module testbench;
    import tsb_pkg::*;
    logic             i_clk = 1'b0;
    logic             i_rst = 1'b1;
    logic             psel = 1'b0, penable = 1'b0, pwrite = 1'b0, i_step_start = 1'b0;
    logic [11:0]      paddr = 12'h000;
    logic [31:0]      pwdata = 32'h0, prdata, rd;
    logic [3:0]       opt = 4'h0;
    logic [15:0]      c0_lim;
    logic             pready, pslverr, err, done, busy, mod_en, run;
    tsb_bcast_s       bc;
    logic [7:0]       clk_cnt;
    logic [3:0][7:0]  trig_cnt;
    int               mismatches = 0, compares = 0;
    always #10 i_clk = ~i_clk;
    tsb_core u_dut (.i_clk(i_clk), .i_rst(i_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .i_step_start(i_step_start), .i_step_option_command(opt), .o_step_done(done), .o_step_busy(busy),
        .o_loop_counter0_limit(c0_lim), .o_sequencer_module_enable(mod_en), .o_sequencer_run(run), .o_bcast(bc));
    tsb_oc_model u_model (.i_clk(i_clk), .i_rst(i_rst), .i_bcast(bc), .o_clk_cnt(clk_cnt), .o_trig_cnt(trig_cnt));
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge i_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge i_clk);
        penable <= 1'b1;
        do @(posedge i_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic step(input logic [3:0] o, input int lim, input tsb_bcast_s exp);
        int n;
        @(posedge i_clk);
        i_step_start <= 1'b1;
        opt <= o;
        @(posedge i_clk);
        i_step_start <= 1'b0;
        #1 n = 1;
        `CHK(bc, exp)
        `CHK(busy, 1'b1)
        while (done !== 1'b1 && n < 100) begin
            @(posedge i_clk);
            #1 n++;
            `CHK(bc, 5'h00)
            `CHK(busy, 1'b1)
        end
        `CHK(n, lim + 1)
        @(posedge i_clk);
        #1;
        `CHK(busy, 1'b0)
    endtask
    task automatic t_regs();
        for (int a = 0; a < 12; a += 4) begin
            apb(1'b0, 12'(a), 32'h0);
            `CHK(rd, 32'h0)
        end
        apb(1'b1, TSB_OFS_STEP_DLY, 32'h0000A5C3);
        apb(1'b0, TSB_OFS_STEP_DLY, 32'h0);
        `CHK(rd, 32'h0000A5C3)
        apb(1'b1, TSB_OFS_C0_LIMIT, 32'h00001234);
        #1;
        `CHK(c0_lim, 16'h1234)
        apb(1'b0, 12'h014, 32'h0);
        `CHK(err, 1'b1)
    endtask
    task automatic t_run();
        apb(1'b1, TSB_OFS_BCAST_EN, 32'h0000001A);
        apb(1'b1, TSB_OFS_STEP_DLY, 32'h0);
        apb(1'b1, TSB_OFS_CONTROL, 32'h3);
        apb(1'b0, TSB_OFS_CONTROL, 32'h0);
        `CHK(rd, 32'h3)
        `CHK({mod_en, run}, 2'b11)
        step(TSB_OPT_BCAST, 0, 5'h1A);
        for (int o = 0; o < 15; o++) step(4'(o), 0, 5'h00);
        apb(1'b1, TSB_OFS_BCAST_EN, 32'h00000005);
        apb(1'b1, TSB_OFS_STEP_DLY, 32'h00000007);
        apb(1'b1, TSB_OFS_C0_LIMIT, 32'h00005555);
        apb(1'b0, TSB_OFS_BCAST_EN, 32'h0);
        `CHK(rd, 32'h0000001A)
        apb(1'b0, TSB_OFS_STEP_DLY, 32'h0);
        `CHK(rd, 32'h0)
        `CHK(c0_lim, 16'h1234)
        apb(1'b1, TSB_OFS_CONTROL, 32'h0);
        apb(1'b1, TSB_OFS_BCAST_EN, 32'h00000005);
        apb(1'b1, TSB_OFS_STEP_DLY, 32'h00000002);
        apb(1'b1, TSB_OFS_CONTROL, 32'h3);
        step(TSB_OPT_BCAST, 2, 5'h05);
        `CHK({clk_cnt, trig_cnt}, {8'h01, 32'h01010101})
        apb(1'b0, TSB_OFS_STATUS, 32'h0);
        `CHK(rd, 32'h0)
    endtask
    task automatic complete_run();
        $display("mismatches %0d compares %0d", mismatches, compares);
        if (mismatches == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge i_clk);
        i_rst <= 1'b0;
        t_regs();
        t_run();
        complete_run();
    end
    // Every test is short, so a few thousand cycles means something hung.
    initial begin
        repeat (5000) @(posedge i_clk);
        mismatches++;
        complete_run();
    end
endmodule // testbench
`default_nettype wire
